// File: cadp_pkg.sv
// Constants, register map and shared types of the CPU arithmetic datapath
package cadp_pkg;
    // Register map over Wishbone (byte addresses, one 32-bit word each)
    localparam logic [3:0] REG_CTL_OFFSET = 4'h0;
    localparam logic [3:0] REG_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] REG_PAGE_OFFSET = 4'h8;
    // Core control fields
    localparam int CTL_TOP_BIT = 3;
    localparam int CTL_WIN_BIT = 2;
    localparam logic CTL_TOP_RESET = 1'b0;
    localparam logic CTL_WIN_RESET = 1'b0;
    // Status word fields
    localparam int ST_C_BIT = 0;
    localparam int ST_Z_BIT = 1;
    localparam int ST_OV_BIT = 2;
    localparam int ST_N_BIT = 3;
    localparam int ST_IPL_LSB = 5;
    localparam int ST_DC_BIT = 8;
    localparam logic [15:0] ST_WRITE_MASK = 16'h01EF;
    localparam logic [15:0] ST_RESET = 16'h0000;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    // Datapath sizes and counts
    localparam int DATA_BYTES_DEF = 1024;
    localparam int DIV_ITER = 16;
    localparam int DIV_CYCLES = 19;
    localparam logic [4:0] SHIFT_MAX = 5'h10;
    localparam logic [2:0] IPL_LOW_MAX = 3'h7;

    typedef enum logic [3:0] {
        ALU_ADD = 4'h0,
        ALU_SUB = 4'h1,
        ALU_AND = 4'h2,
        ALU_IOR = 4'h3,
        ALU_XOR = 4'h4,
        ALU_SL = 4'h5,
        ALU_LSR = 4'h6,
        ALU_ASR = 4'h7
    } cadp_alu_op_type;

    typedef enum logic [2:0] {
        MUL_SS = 3'h0,
        MUL_UU = 3'h1,
        MUL_S_LIT = 3'h2,
        MUL_U_LIT = 3'h3,
        MUL_US = 3'h4,
        MUL_BB = 3'h5
    } cadp_mul_mode_type;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN = 2'b01,
        DIV_FIX = 2'b10,
        DIV_WRITE = 2'b11
    } cadp_div_state_type;

    typedef struct packed {
        logic ctl_top;
        logic ctl_win;
        logic [15:0] status;
        logic [7:0] page;
        logic ack;
        logic [15:0] bus_rdat;
        logic [15:0] alu_res;
        logic alu_reg_we;
        logic alu_mem_we;
        logic [31:0] mul_prod;
        logic [15:0] shf_res;
        cadp_div_state_type div_state;
        logic [4:0] div_cnt;
        logic [15:0] div_rem;
        logic [15:0] div_quo;
        logic [15:0] div_dvs;
        logic div_negq;
        logic div_negr;
        logic [15:0] w0;
        logic [15:0] w1;
        logic div_done;
        logic [15:0] rd_data;
    } cadp_state_type;
endpackage

// File: cadp_core.sv
// CPU arithmetic datapath: control register, ALU, multiplier, divider, shifter, data-space map
`timescale 1ns/10ps
module cadp_core
    import cadp_pkg::*;
#(
    parameter int DATA_BYTES = DATA_BYTES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ipl_top_set_i,
    output logic [3:0] priority_level_o,
    output logic user_irq_disable_o,
    input wire logic alu_valid_i,
    input wire cadp_alu_op_type alu_op_i,
    input wire logic alu_byte_i,
    input wire logic alu_a_mem_i,
    input wire logic alu_dst_mem_i,
    input wire logic [15:0] reg_opnd_a_i,
    input wire logic [15:0] mem_opnd_i,
    input wire logic [15:0] alu_b_i,
    output logic [15:0] alu_result_o,
    output logic alu_reg_we_o,
    output logic alu_mem_we_o,
    input wire logic mul_valid_i,
    input wire cadp_mul_mode_type mul_mode_i,
    input wire logic [15:0] mul_a_i,
    input wire logic [15:0] mul_b_i,
    output logic [31:0] mul_prod_o,
    input wire logic div_start_i,
    input wire logic div_long_i,
    input wire logic div_signed_i,
    input wire logic div_hold_i,
    input wire logic [15:0] div_hi_i,
    input wire logic [15:0] div_lo_i,
    input wire logic [15:0] div_divisor_i,
    output logic div_busy_o,
    output logic div_done_o,
    output logic [15:0] work_reg_zero_o,
    output logic [15:0] work_reg_one_o,
    input wire logic shf_valid_i,
    input wire logic shf_arith_i,
    input wire logic shf_mem_i,
    input wire logic [5:0] shf_amt_i,
    output logic [15:0] shf_result_o,
    input wire logic rd_en_i,
    input wire logic rd_byte_i,
    input wire logic [15:0] rd_ea_i,
    output logic [15:0] rd_data_o,
    output logic [22:0] prog_addr_o,
    input wire logic [15:0] prog_rd_data_i,
    input wire logic wr_en_i,
    input wire logic wr_byte_i,
    input wire logic [15:0] wr_ea_i,
    input wire logic [15:0] wr_data_i
);
    localparam int RAM_WORDS = DATA_BYTES / 2;
    localparam int RAM_AW = $clog2(RAM_WORDS);
    localparam logic [16:0] DATA_LIMIT = 17'(DATA_BYTES);
    localparam int DIV_CHK = DIV_CYCLES - 2;

    cadp_state_type st_reg;
    cadp_state_type st_next;
    logic [15:0] ram [RAM_WORDS];

    // 0 control, 1 status, 2 page, 3 unmapped
    function automatic logic [1:0] reg_index(input logic [3:0] adr);
        case (adr)
            REG_CTL_OFFSET: reg_index = 2'd0;
            REG_STATUS_OFFSET: reg_index = 2'd1;
            REG_PAGE_OFFSET: reg_index = 2'd2;
            default: reg_index = 2'd3;
        endcase
    endfunction

    logic bus_req;
    logic bus_wr;
    logic [15:0] lane_mask;
    logic [15:0] ctl_view;
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr = bus_req && wb_we_i && st_reg.ack;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign ctl_view = {12'h000, st_reg.ctl_top, st_reg.ctl_win, 2'b00};

    // ALU operand path
    logic [15:0] alu_a;
    logic alu_sub;
    logic [15:0] alu_bx;
    logic [16:0] sum17;
    logic [8:0] sum9;
    logic [4:0] sum5;
    assign alu_a = alu_a_mem_i ? mem_opnd_i : reg_opnd_a_i;
    assign alu_sub = (alu_op_i == ALU_SUB);
    assign alu_bx = alu_sub ? ~alu_b_i : alu_b_i;
    // Subtract as a + ~b + 1, so carries come out as inverted borrows
    assign sum17 = {1'b0, alu_a} + {1'b0, alu_bx} + {16'h0000, alu_sub};
    assign sum9 = {1'b0, alu_a[7:0]} + {1'b0, alu_bx[7:0]} + {8'h00, alu_sub};
    assign sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_bx[3:0]} + {4'h0, alu_sub};

    // Multiplier operand extension to 17 bits
    logic [16:0] mul_ea;
    logic [16:0] mul_eb;
    logic [33:0] mul_full;
    always_comb begin
        mul_ea = {1'b0, mul_a_i};
        mul_eb = {1'b0, mul_b_i};
        case (mul_mode_i)
            MUL_SS: begin
                mul_ea = {mul_a_i[15], mul_a_i};
                mul_eb = {mul_b_i[15], mul_b_i};
            end
            MUL_S_LIT: begin
                mul_ea = {mul_a_i[15], mul_a_i};
                mul_eb = {12'h000, mul_b_i[4:0]};
            end
            MUL_U_LIT: mul_eb = {12'h000, mul_b_i[4:0]};
            MUL_US: mul_eb = {mul_b_i[15], mul_b_i};
            MUL_BB: begin
                mul_ea = {9'h000, mul_a_i[7:0]};
                mul_eb = {9'h000, mul_b_i[7:0]};
            end
            default: begin
                mul_ea = {1'b0, mul_a_i};
                mul_eb = {1'b0, mul_b_i};
            end
        endcase
    end
    assign mul_full = 34'($signed(mul_ea) * $signed(mul_eb));

    // Barrel shifter; magnitudes beyond 16 clamp to 16
    logic [15:0] shf_op;
    logic [5:0] shf_mag;
    logic [4:0] shf_n;
    logic [31:0] shf_right;
    logic [31:0] shf_left;
    logic [15:0] shf_val;
    assign shf_op = shf_mem_i ? mem_opnd_i : reg_opnd_a_i;
    assign shf_mag = shf_amt_i[5] ? 6'(-shf_amt_i) : shf_amt_i;
    assign shf_n = (shf_mag > {1'b0, SHIFT_MAX}) ? SHIFT_MAX : shf_mag[4:0];
    assign shf_right = shf_arith_i ? 32'($signed({{16{shf_op[15]}}, shf_op}) >>> shf_n)
                                   : ({16'h0000, shf_op} >> shf_n);
    assign shf_left = {16'h0000, shf_op} << shf_n;
    assign shf_val = shf_amt_i[5] ? shf_left[15:0] : shf_right[15:0];

    // Divider operand preparation on magnitudes
    logic [31:0] div_num;
    logic [31:0] div_num_mag;
    logic [15:0] div_den_mag;
    logic div_num_neg;
    logic div_den_neg;
    logic [16:0] div_trial;
    logic div_fits;
    assign div_num = div_long_i ? {div_hi_i, div_lo_i}
        : {(div_signed_i ? {16{div_lo_i[15]}} : 16'h0000), div_lo_i};
    assign div_num_neg = div_signed_i && div_num[31];
    assign div_den_neg = div_signed_i && div_divisor_i[15];
    assign div_num_mag = div_num_neg ? 32'(-div_num) : div_num;
    assign div_den_mag = div_den_neg ? 16'(-div_divisor_i) : div_divisor_i;
    assign div_trial = {st_reg.div_rem, st_reg.div_quo[15]};
    assign div_fits = div_trial >= {1'b0, st_reg.div_dvs};

    // Data-space read mapping through the read generator
    logic rd_in_ram;
    logic [15:0] rd_word;
    assign rd_in_ram = !rd_ea_i[15] && ({1'b0, rd_ea_i} < DATA_LIMIT);
    assign prog_addr_o = {st_reg.page, rd_ea_i[14:0]};
    always_comb begin
        rd_word = 16'h0000;
        if (rd_ea_i[15]) begin
            if (st_reg.ctl_win) begin
                rd_word = prog_rd_data_i;
            end
        end else if (rd_in_ram) begin
            rd_word = ram[rd_ea_i[RAM_AW:1]];
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.ack = bus_req && !st_reg.ack;
        st_next.alu_reg_we = 1'b0;
        st_next.alu_mem_we = 1'b0;
        st_next.div_done = 1'b0;
        // Bus read data is captured with ack so it is valid at the ack edge
        case (reg_index(wb_adr_i))
            2'd0: st_next.bus_rdat = ctl_view;
            2'd1: st_next.bus_rdat = st_reg.status;
            2'd2: st_next.bus_rdat = {8'h00, st_reg.page};
            default: st_next.bus_rdat = 16'h0000;
        endcase
        if (bus_wr && wb_sel_i[0]) begin
            case (reg_index(wb_adr_i))
                2'd0: begin
                    st_next.ctl_win = wb_dat_i[CTL_WIN_BIT];
                    if (!wb_dat_i[CTL_TOP_BIT]) begin
                        st_next.ctl_top = 1'b0;
                    end
                end
                2'd2: st_next.page = wb_dat_i[7:0];
                default: st_next.page = st_next.page;
            endcase
        end
        if (bus_wr && reg_index(wb_adr_i) == 2'd1) begin
            st_next.status = (st_reg.status & ~(lane_mask & ST_WRITE_MASK))
                | (wb_dat_i[15:0] & lane_mask & ST_WRITE_MASK);
        end
        // Entry to a top-priority level wins over a software clear
        if (ipl_top_set_i) begin
            st_next.ctl_top = 1'b1;
        end
        if (alu_valid_i) begin
            st_next.alu_reg_we = !alu_dst_mem_i;
            st_next.alu_mem_we = alu_dst_mem_i;
            case (alu_op_i)
                ALU_ADD, ALU_SUB: begin
                    st_next.alu_res = sum17[15:0];
                    st_next.status[ST_C_BIT] = alu_byte_i ? sum9[8] : sum17[16];
                    st_next.status[ST_DC_BIT] = alu_byte_i ? sum5[4] : sum9[8];
                    st_next.status[ST_OV_BIT] = alu_byte_i
                        ? (alu_a[7] == alu_bx[7]) && (sum9[7] != alu_a[7])
                        : (alu_a[15] == alu_bx[15]) && (sum17[15] != alu_a[15]);
                end
                ALU_AND: st_next.alu_res = alu_a & alu_b_i;
                ALU_IOR: st_next.alu_res = alu_a | alu_b_i;
                ALU_XOR: st_next.alu_res = alu_a ^ alu_b_i;
                ALU_SL: begin
                    st_next.alu_res = {alu_a[14:0], 1'b0};
                    st_next.status[ST_C_BIT] = alu_byte_i ? alu_a[7] : alu_a[15];
                end
                ALU_LSR, ALU_ASR: begin
                    st_next.alu_res = {(alu_op_i == ALU_ASR) && alu_a[15], alu_a[15:1]};
                    if (alu_byte_i) begin
                        st_next.alu_res[7] = (alu_op_i == ALU_ASR) && alu_a[7];
                    end
                    st_next.status[ST_C_BIT] = alu_a[0];
                end
                default: st_next.alu_res = alu_a;
            endcase
            // Byte operations carry the upper byte of operand A through to the result unchanged
            if (alu_byte_i) begin
                st_next.alu_res[15:8] = alu_a[15:8];
            end
            st_next.status[ST_N_BIT] = alu_byte_i ? st_next.alu_res[7] : st_next.alu_res[15];
            st_next.status[ST_Z_BIT] = alu_byte_i ? (st_next.alu_res[7:0] == 8'h00)
                                                  : (st_next.alu_res == 16'h0000);
        end
        if (mul_valid_i) begin
            st_next.mul_prod = mul_full[31:0];
        end
        if (shf_valid_i) begin
            st_next.shf_res = shf_val;
        end
        if (rd_en_i) begin
            st_next.rd_data = rd_byte_i
                ? {8'h00, (rd_ea_i[0] ? rd_word[15:8] : rd_word[7:0])} : rd_word;
        end
        case (st_reg.div_state)
            DIV_IDLE: begin
                if (div_start_i) begin
                    st_next.div_state = DIV_RUN;
                    st_next.div_cnt = 5'd0;
                    st_next.div_rem = div_num_mag[31:16];
                    st_next.div_quo = div_num_mag[15:0];
                    st_next.div_dvs = div_den_mag;
                    st_next.div_negq = div_num_neg ^ div_den_neg;
                    st_next.div_negr = div_num_neg;
                end
            end
            DIV_RUN: begin
                // A held divide keeps every partial result in place
                if (!div_hold_i) begin
                    st_next.div_rem = div_fits ? 16'(div_trial - {1'b0, st_reg.div_dvs})
                                               : div_trial[15:0];
                    st_next.div_quo = {st_reg.div_quo[14:0], div_fits};
                    st_next.div_cnt = st_reg.div_cnt + 5'd1;
                    if (st_reg.div_cnt == 5'(DIV_ITER - 1)) begin
                        st_next.div_state = DIV_FIX;
                    end
                end
            end
            DIV_FIX: begin
                if (!div_hold_i) begin
                    st_next.w0 = st_reg.div_negq ? 16'(-st_reg.div_quo) : st_reg.div_quo;
                    st_next.w1 = st_reg.div_negr ? 16'(-st_reg.div_rem) : st_reg.div_rem;
                    st_next.div_done = 1'b1;
                    st_next.div_state = DIV_WRITE;
                end
            end
            DIV_WRITE: st_next.div_state = DIV_IDLE;
            default: st_next.div_state = DIV_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.ctl_top <= CTL_TOP_RESET;
            st_reg.ctl_win <= CTL_WIN_RESET;
            st_reg.status <= ST_RESET;
            st_reg.page <= PAGE_RESET;
            st_reg.div_state <= DIV_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Write generator: byte writes land on the lane the address selects
    always_ff @(posedge clk_i) begin
        if (wr_en_i && !wr_ea_i[15] && ({1'b0, wr_ea_i} < DATA_LIMIT)) begin
            if (!wr_byte_i) begin
                ram[wr_ea_i[RAM_AW:1]] <= wr_data_i;
            end else if (wr_ea_i[0]) begin
                ram[wr_ea_i[RAM_AW:1]][15:8] <= wr_data_i[7:0];
            end else begin
                ram[wr_ea_i[RAM_AW:1]][7:0] <= wr_data_i[7:0];
            end
        end
    end

    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = {16'h0000, st_reg.bus_rdat};
    assign priority_level_o = {st_reg.ctl_top, st_reg.status[ST_IPL_LSB +: 3]};
    assign user_irq_disable_o = st_reg.ctl_top
        || (st_reg.status[ST_IPL_LSB +: 3] == IPL_LOW_MAX);
    assign alu_result_o = st_reg.alu_res;
    assign alu_reg_we_o = st_reg.alu_reg_we;
    assign alu_mem_we_o = st_reg.alu_mem_we;
    assign mul_prod_o = st_reg.mul_prod;
    assign shf_result_o = st_reg.shf_res;
    assign div_busy_o = (st_reg.div_state != DIV_IDLE);
    assign div_done_o = st_reg.div_done;
    assign work_reg_zero_o = st_reg.w0;
    assign work_reg_one_o = st_reg.w1;
    assign rd_data_o = st_reg.rd_data;

    // Checking helpers: unheld busy cycles and the operands of a divide
    logic [4:0] chk_cnt;
    logic [15:0] chk_num;
    logic [15:0] chk_den;
    logic chk_plain;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chk_cnt <= 5'd0;
            chk_num <= 16'h0000;
            chk_den <= 16'h0000;
            chk_plain <= 1'b0;
        end else if (!div_busy_o && div_start_i) begin
            chk_cnt <= 5'd0;
            chk_num <= div_lo_i;
            chk_den <= div_divisor_i;
            chk_plain <= !div_long_i && !div_signed_i;
        end else if (div_busy_o && !(div_hold_i && st_reg.div_state != DIV_WRITE)) begin
            chk_cnt <= chk_cnt + 5'd1;
        end
    end

    AST_CTL_RESERVED: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && !wb_we_i && wb_adr_i == REG_CTL_OFFSET |-> (wb_dat_o & 32'hFFFFFFF3) == 0)
        else $error("reserved control bits read nonzero");
    AST_TOP_CLEAR_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(priority_level_o[3]) |-> $past(ipl_top_set_i))
        else $error("priority top bit set without hardware cause");
    AST_WIN_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && wb_sel_i[0] && wb_adr_i == REG_CTL_OFFSET
        |=> st_reg.ctl_win == $past(wb_dat_i[CTL_WIN_BIT]))
        else $error("window enable did not follow write");
    AST_SUB_EQUAL: assert property (@(posedge clk_i) disable iff (rst_i)
        alu_valid_i && alu_op_i == ALU_SUB && !alu_byte_i && alu_a == alu_b_i
        |=> st_reg.status[ST_Z_BIT] && st_reg.status[ST_C_BIT] && !st_reg.status[ST_N_BIT])
        else $error("equal subtract flags wrong");
    AST_MUL_UU: assert property (@(posedge clk_i) disable iff (rst_i)
        mul_valid_i && mul_mode_i == MUL_UU
        |=> mul_prod_o == {16'h0000, $past(mul_a_i)} * {16'h0000, $past(mul_b_i)})
        else $error("unsigned product wrong");
    AST_SHIFT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        shf_valid_i && shf_amt_i == 6'h00 |=> shf_result_o == $past(shf_op))
        else $error("zero shift changed operand");
    AST_RD_OUTSIDE: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_en_i && !rd_ea_i[15] && !rd_in_ram |=> rd_data_o == 16'h0000)
        else $error("read outside memory not zero");
    AST_DIV_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
        div_done_o |-> chk_cnt == DIV_CHK)
        else $error("divide did not take its cycle count");
    AST_DIV_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
        div_done_o && chk_plain && chk_den != 16'h0000
        |-> (32'(work_reg_zero_o) * 32'(chk_den) + 32'(work_reg_one_o) == 32'(chk_num))
            && (work_reg_one_o < chk_den))
        else $error("quotient or remainder wrong");
    AST_IRQ_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
        priority_level_o[3] |-> user_irq_disable_o)
        else $error("user interrupts not disabled");

    COV_DIV_DONE: cover property (@(posedge clk_i) disable iff (rst_i)
        div_done_o && chk_plain);
    COV_WINDOW_READ: cover property (@(posedge clk_i) disable iff (rst_i)
        rd_en_i && rd_ea_i[15] && st_reg.ctl_win);
    COV_TOP_CLEARED: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(priority_level_o[3]));
    COV_MUL_MIXED: cover property (@(posedge clk_i) disable iff (rst_i)
        mul_valid_i && mul_mode_i == MUL_US && mul_b_i[15]);
endmodule

// File: cadp_prog_model.sv
// Program-space model that answers reads through the data-space window
`timescale 1ns/10ps
module cadp_prog_model (
    input wire logic [22:0] prog_addr_i,
    output logic [15:0] prog_rd_data_o
);
    // Page bits are folded in, so a wrong page or offset gives a wrong word
    assign prog_rd_data_o = prog_addr_i[15:0] ^ {prog_addr_i[22:15], 8'hA5};
endmodule

// File: cadp_core_tb.sv
// Self-checking bench of the CPU arithmetic datapath
`timescale 1ns/10ps
module cadp_core_tb;
    import cadp_pkg::*;
    logic clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, ipl_top_set_i = '0;
    logic alu_valid_i = '0, alu_byte_i = '0, alu_a_mem_i = '0, alu_dst_mem_i = '0, mul_valid_i = '0;
    logic div_start_i = '0, div_long_i = '0, div_signed_i = '0, div_hold_i = '0, shf_valid_i = '0;
    logic shf_arith_i = '0, shf_mem_i = '0, rd_en_i = '0, rd_byte_i = '0, wr_en_i = '0, wr_byte_i = '0;
    logic [3:0] wb_adr_i = '0, wb_sel_i = '0, priority_level_o, m;
    logic [5:0] shf_amt_i = '0;
    logic [15:0] reg_opnd_a_i = '0, mem_opnd_i = '0, alu_b_i = '0, mul_a_i = '0, mul_b_i = '0;
    logic [15:0] div_hi_i = '0, div_lo_i = '0, div_divisor_i = '0, rd_ea_i = '0, wr_ea_i = '0;
    logic [15:0] wr_data_i = '0, alu_result_o, work_reg_zero_o, work_reg_one_o, shf_result_o;
    logic [15:0] rd_data_o, prog_rd_data_i, a, b;
    logic [31:0] wb_dat_i = '0, wb_dat_o, mul_prod_o, e, q;
    logic [22:0] prog_addr_o;
    logic [1:0] k;
    logic wb_ack_o, user_irq_disable_o, alu_reg_we_o, alu_mem_we_o, div_busy_o, div_done_o;
    cadp_alu_op_type alu_op_i = ALU_ADD;
    cadp_mul_mode_type mul_mode_i = MUL_SS;
    int err_count = 0, samples_checked = 0, n;
    // Row: unit (0 alu, 1 mul, 2 shift), mode, A, B, expected (alu: status above result)
    logic [69:0] rows [21] = '{{2'h0, ALU_ADD, 16'h1234, 16'h1111, 32'h2345},
        {2'h0, ALU_SUB, 16'h0005, 16'h0007, 32'h8FFFE}, {2'h0, ALU_AND, 16'hF0F0, 16'h3C3C, 32'h3030},
        {2'h0, ALU_IOR, 16'hF0F0, 16'h0F0F, 32'h8FFFF}, {2'h0, ALU_XOR, 16'hFFFF, 16'h00FF, 32'h8FF00},
        {2'h0, 4'h8, 16'h12FF, 16'h0001, 32'h1031200}, {2'h0, ALU_SL, 16'h0001, 16'h0004, 32'h2},
        {2'h0, ALU_LSR, 16'h8000, 16'h0004, 32'h4000}, {2'h0, ALU_ASR, 16'h8000, 16'h0004, 32'hC000},
        {2'h1, 1'h0, MUL_SS, 16'hFFFF, 16'h0002, 32'hFFFFFFFE},
        {2'h1, 1'h0, MUL_UU, 16'hFFFF, 16'h0002, 32'h1FFFE},
        {2'h1, 1'h0, MUL_S_LIT, 16'hFFFF, 16'hFFE3, 32'hFFFFFFFD},
        {2'h1, 1'h0, MUL_U_LIT, 16'hFFFF, 16'hFFE3, 32'h2FFFD},
        {2'h1, 1'h0, MUL_US, 16'h0002, 16'hFFFF, 32'hFFFFFFFE},
        {2'h1, 1'h0, MUL_BB, 16'h12FF, 16'h34FF, 32'hFE01}, {2'h2, 4'h1, 16'h8000, 16'h4, 32'hF800},
        {2'h2, 4'h0, 16'h8000, 16'h4, 32'h800}, {2'h2, 4'h0, 16'h0001, 16'h3C, 32'h10},
        {2'h2, 4'h0, 16'h1234, 16'h0, 32'h1234}, {2'h2, 4'h1, 16'h8000, 16'h10, 32'hFFFF},
        {2'h0, ALU_SUB, 16'h4321, 16'h4321, 32'h1030000}};
    cadp_core u_cadp_core (.*);
    cadp_prog_model u_cadp_prog_model (.prog_addr_i(prog_addr_o), .prog_rd_data_o(prog_rd_data_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic test_done;
        $display("Checked %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // A wait that runs out of its bound ends the run
    task automatic tmo(input int c);
        if (c >= 40) begin
            err_count++;
            test_done;
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, ad, 4'hF, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        tmo(n);
        #1;
    endtask
    task automatic mem(input logic w, bw, input logic [15:0] wa, wd, input logic rb,
                       input logic [15:0] ra);
        @(posedge clk_i);
        {wr_en_i, wr_byte_i, wr_ea_i, wr_data_i, rd_en_i, rd_byte_i, rd_ea_i}
            <= {w, bw, wa, wd, 1'h1, rb, ra};
        @(posedge clk_i);
        {wr_en_i, rd_en_i} <= 2'h0;
        #1;
    endtask
    // Signed long or unsigned short divide; a second start with a new divisor is sent while busy
    task automatic dv(input logic lg, input logic [15:0] hi, lo, dvs, input int h, input logic [31:0] x);
        @(posedge clk_i);
        {div_start_i, div_long_i, div_signed_i, div_hi_i, div_lo_i, div_divisor_i}
            <= {1'h1, lg, lg, hi, lo, dvs};
        @(posedge clk_i);
        div_divisor_i <= 16'h0003;
        n = 0;
        do begin
            @(posedge clk_i);
            div_start_i <= 1'h0;
            div_hold_i <= (n >= 4 && n < 4 + h);
            n++;
        end while (div_done_o !== 1'b1 && n < 40);
        tmo(n);
        // n starts counting at the edge after the one that takes the start
        chk(n, DIV_CYCLES - 1 + h);
        chk({work_reg_one_o, work_reg_zero_o}, x);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        chk({wb_ack_o, div_busy_o, user_irq_disable_o, priority_level_o, rd_data_o}, '0);
        wb(0, REG_CTL_OFFSET, '0);
        chk(q, '0);
        foreach (rows[i]) begin
            {k, m, a, b, e} = rows[i];
            @(posedge clk_i);
            {alu_valid_i, mul_valid_i, shf_valid_i} <= {k == 2'h0, k == 2'h1, k == 2'h2};
            alu_op_i <= cadp_alu_op_type'({1'h0, m[2:0]});
            mul_mode_i <= cadp_mul_mode_type'(m[2:0]);
            {alu_byte_i, shf_arith_i, alu_b_i, mul_a_i, mul_b_i} <= {m[3], m[0], b, a, b};
            {alu_a_mem_i, alu_dst_mem_i, shf_mem_i, shf_amt_i} <= {{3{i[0]}}, b[5:0]};
            reg_opnd_a_i <= a ^ {16{i[0]}};
            mem_opnd_i <= ~a ^ {16{i[0]}};
            @(posedge clk_i);
            {alu_valid_i, mul_valid_i, shf_valid_i} <= 3'h0;
            #1;
            if (k == 2'h1) chk(mul_prod_o, e);
            if (k == 2'h2) chk(shf_result_o, e);
            if (k == 2'h0) begin
                chk({alu_reg_we_o, alu_mem_we_o, alu_result_o}, {~i[0], i[0], e[15:0]});
            end
            if (k == 2'h0 && m[2:0] < 3'h5) begin
                wb(0, REG_STATUS_OFFSET, '0);
                chk(q, e[31:16]);
            end
        end
        wb(1, REG_CTL_OFFSET, 32'hFFFFFFFF);
        wb(0, REG_CTL_OFFSET, '0);
        chk(q, 32'h4);
        @(posedge clk_i);
        ipl_top_set_i <= 1'h1;
        @(posedge clk_i);
        ipl_top_set_i <= 1'h0;
        wb(0, REG_CTL_OFFSET, '0);
        chk({q[15:0], user_irq_disable_o, priority_level_o}, 32'h198);
        wb(1, REG_CTL_OFFSET, 32'h4);
        wb(1, REG_STATUS_OFFSET, 32'hE0);
        wb(0, REG_CTL_OFFSET, '0);
        chk({q[15:0], user_irq_disable_o, priority_level_o}, 32'h97);
        wb(1, REG_STATUS_OFFSET, '0);
        wb(1, REG_PAGE_OFFSET, 32'h5);
        wb(0, REG_PAGE_OFFSET, '0);
        chk(q, 32'h5);
        wb(0, 4'hC, '0);
        chk(q, '0);
        mem(1, 0, 16'h0010, 16'hBEEF, 0, 16'h0010);
        mem(1, 0, 16'h0012, 16'h1234, 1, 16'h0011);
        chk(rd_data_o, 32'hBE);
        mem(1, 1, 16'h0013, 16'h0056, 0, 16'h0010);
        chk(rd_data_o, 32'hBEEF);
        mem(1, 0, 16'h0402, 16'h5555, 0, 16'h0012);
        chk(rd_data_o, 32'h5634);
        mem(0, 0, '0, '0, 0, 16'h0402);
        chk(rd_data_o, '0);
        mem(0, 0, '0, '0, 0, 16'h8123);
        chk(rd_data_o, 32'h8486);
        wb(1, REG_CTL_OFFSET, '0);
        mem(0, 0, '0, '0, 0, 16'h8123);
        chk(rd_data_o, '0);
        dv(1, 16'hFFFF, 16'hFFF9, 16'h0002, 0, 32'hFFFFFFFD);
        dv(0, 16'hFFFF, 16'h0064, 16'h0007, 3, 32'h2000E);
        test_done;
    end
endmodule
